// ===== logic/grc_gripper_core.sv
// Command interpreter, status memory and indicator logic of the gripper controller
// Notes on behaviour
// RL1: Supply lamp lit steadily when powered, running
// RL2: Network lamp: off, blink unconnected, on connected
// RL3: Fault lamp: off, on minor/boot, blink major
// RL4: Major fault blocks operation until fresh activation
// RL5: Bit 0 is least significant in bytes
// RL6: Six command bytes, six status bytes, from zero
// RL7: Control bit 0 resets or activates gripper
// RL8: Activate first; clearing resets and clears faults
// RL9: Nothing but reset while activation bit low
// RL10: Go bit stops or moves toward target
// RL11: No motion without go, except homing, release
// RL12: Release bit opens slowly to mechanical limits
// RL13: Release completion is fault, motion refused
// RL14: Release outranks all bits but activation
// RL15: Target byte: zero open, all ones closed
// RL16: Rate applies immediately, never starts motion
// RL17: Strength sets current limit; zero is minimum
// RL18: Over-limit current stops fingers, reports contact
// RL19: Current limit ignored for short initial travel
// RL20: Spare command bits written zero, ignored
// RL21: Target echo updates only on accepted command
// RL22: Status bit 0 echoes the activation bit
// RL23: Contact field reports moving, stops, at target
// RL24: Fault 5 early action, 7 without activation
// RL25: Status byte 3 returns last accepted target
module grc_gripper_core import grc_pkg::*; #(
  parameter int BLINK_CYCLES = BLINK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Shared memory byte port, host side
  input wire logic memWrEn,
  input wire logic memRdEn,
  input wire logic [2:0] memAddr,
  input wire logic [7:0] memWrData,
  output logic [7:0] memRdData,
  output logic memRdValid,
  // Board and network pins
  input wire logic powerGood,
  input wire logic netDetected,
  input wire logic netConnected,
  input wire logic commReady,
  // Actuator feedback pins
  input wire logic [7:0] fingerPos,
  input wire logic [7:0] motorCurrent,
  input wire logic axesAtLimit,
  // Actuator drive
  output logic motorRun,
  output logic motorClose,
  output logic [7:0] motorRate,
  output logic [8:0] currentLimit,
  // Indicator lamps
  output logic ledSupply,
  output logic ledNetwork,
  output logic ledFault
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int SYNC_W = 20;
  logic [SYNC_W-1:0] pinsRaw;
  logic [SYNC_W-1:0] syncA_r;
  logic [SYNC_W-1:0] syncB_r;
  assign pinsRaw = {powerGood, netDetected, netConnected, commReady,
                    fingerPos, motorCurrent};
  // Two flops per pin bit
  for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        syncA_r[i] <= 1'b0;
        syncB_r[i] <= 1'b0;
      end else begin
        syncA_r[i] <= pinsRaw[i];
        syncB_r[i] <= syncA_r[i];
      end
    end
  end
  logic limA_r, limB_r;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      limA_r <= 1'b0;
      limB_r <= 1'b0;
    end else begin
      limA_r <= axesAtLimit;
      limB_r <= limA_r;
    end
  end
  logic pwrS, netS, connS, commS, limS;
  logic [7:0] posS, curS;
  assign {pwrS, netS, connS, commS, posS, curS} = syncB_r;
  assign limS = limB_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command bytes
  logic [7:0] control_r, target_r, rate_r, strength_r;
  logic actBit, moveBit, releaseBit;
  // Only the documented control bits are used; spare bytes are not stored
  assign actBit = control_r[BIT_ACTIVATE]; // RL5 RL20
  assign moveBit = control_r[BIT_MOVE];
  assign releaseBit = control_r[BIT_RELEASE];

  // Host writes into the command space
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      control_r <= RST_CONTROL;
      target_r <= RST_TARGET;
      rate_r <= RST_RATE;
      strength_r <= RST_STRENGTH;
    end else if (memWrEn) begin
      case (memAddr) // RL6
        OFS_CONTROL: control_r <= memWrData;
        OFS_TARGET: target_r <= memWrData;
        OFS_RATE: rate_r <= memWrData;
        OFS_STRENGTH: strength_r <= memWrData;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  grc_state_t state_r;
  logic moving_r, goPrev_r;
  logic [1:0] contact_r;
  logic [3:0] fault_r;
  logic [7:0] echo_r, startPos_r;
  logic [7:0] travel;
  logic accept, pastIgnore, overLimit, atTarget;

  // Strength zero still gives the floor current
  assign currentLimit = CURRENT_FLOOR + {1'b0, strength_r}; // RL17
  assign travel = (posS >= startPos_r) ? posS - startPos_r : startPos_r - posS;
  assign pastIgnore = travel >= IGNORE_TRAVEL; // RL19
  assign overLimit = {1'b0, curS} > currentLimit;
  assign atTarget = posS == echo_r;
  // New command: go bit rising, or target changed while go held
  assign accept = state_r == ST_READY && moveBit && !releaseBit
                  && (!goPrev_r || target_r != echo_r);

  // Go bit history for acceptance
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      goPrev_r <= 1'b0;
    end else begin
      goPrev_r <= moveBit && state_r == ST_READY;
    end
  end

  // State transitions
  always_ff @(posedge mclk) begin
    if (!resetn || !actBit) begin
      state_r <= ST_RESET; // RL8 RL9
    end else begin
      case (state_r)
        ST_RESET: state_r <= ST_ACTIVATE; // RL7
        ST_ACTIVATE: if (limS) state_r <= ST_READY;
        ST_READY: begin
          if (releaseBit) begin
            state_r <= ST_RELEASE; // RL14
          end else if (moving_r && curS >= OVERCURRENT_LEVEL) begin
            state_r <= ST_MAJOR;
          end
        end
        ST_RELEASE: if (limS) state_r <= ST_MAJOR; // RL13
        ST_MAJOR: state_r <= ST_MAJOR; // RL4
        default: state_r <= ST_RESET;
      endcase
    end
  end

  // Fault code register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fault_r <= FLT_NONE;
    end else if (!actBit) begin
      fault_r <= (moveBit || releaseBit) ? FLT_NO_ACTIVATE : FLT_NONE; // RL8 RL24
    end else begin
      case (state_r)
        ST_ACTIVATE: if (moveBit || releaseBit) fault_r <= FLT_NOT_READY; // RL24
        ST_READY: begin
          if (releaseBit) begin
            fault_r <= FLT_RELEASING;
          end else if (moving_r && curS >= OVERCURRENT_LEVEL) begin
            fault_r <= FLT_OVERCURRENT;
          end else if (accept) begin
            fault_r <= FLT_NONE;
          end
        end
        ST_RELEASE: fault_r <= limS ? FLT_RELEASED : FLT_RELEASING;
        default: ;
      endcase
    end
  end

  // Motion tracking in the ready state
  always_ff @(posedge mclk) begin
    if (!resetn || state_r != ST_READY || releaseBit || !moveBit) begin
      moving_r <= 1'b0; // RL10 RL11
    end else if (accept) begin
      moving_r <= 1'b1;
    end else if (moving_r && (atTarget || (pastIgnore && overLimit))) begin
      moving_r <= 1'b0; // RL18
    end
  end

  // Contact field and start position
  always_ff @(posedge mclk) begin
    if (!resetn || state_r != ST_READY) begin
      contact_r <= OBJ_MOVING;
      startPos_r <= 8'h00;
    end else if (accept) begin
      contact_r <= OBJ_MOVING;
      startPos_r <= posS;
    end else if (moving_r && atTarget) begin
      contact_r <= OBJ_AT_TARGET; // RL23
    end else if (moving_r && pastIgnore && overLimit) begin
      contact_r <= motorClose ? OBJ_CLOSE_STOP : OBJ_OPEN_STOP; // RL18 RL23
    end
  end

  // Target echo taken only when a command is accepted
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      echo_r <= RST_TARGET;
    end else if (accept) begin
      echo_r <= target_r; // RL21 RL25
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Actuator drive
  // Homing and release open the fingers; go moves toward the target
  always_comb begin
    motorRun = 1'b0;
    motorClose = 1'b0;
    motorRate = rate_r; // RL16
    case (state_r)
      ST_ACTIVATE: begin
        motorRun = !limS;
        motorRate = HOMING_RATE;
      end
      ST_RELEASE: begin
        motorRun = !limS; // RL12
        motorRate = RELEASE_RATE;
      end
      ST_READY: begin
        motorRun = moving_r && moveBit && !releaseBit; // RL10 RL11
        motorClose = echo_r > posS; // RL15
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status space readback
  logic [1:0] actStatus;
  logic [3:0] faultShown;
  logic [7:0] stateByte;
  assign actStatus = (state_r == ST_READY) ? ACT_DONE :
                     (state_r == ST_ACTIVATE) ? ACT_BUSY : ACT_IDLE;
  assign faultShown = (!commS && fault_r == FLT_NONE) ? FLT_COMM_BOOT : fault_r;
  // Field order: act echo, spares, go echo, activation status, contact
  assign stateByte = {contact_r[1], contact_r[0], actStatus[1], actStatus[0],
                      moveBit && state_r == ST_READY, 2'h0, actBit}; // RL22 RL23

  // Registered read of the status bytes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      memRdData <= 8'h00;
      memRdValid <= 1'b0;
    end else begin
      memRdValid <= memRdEn;
      if (memRdEn) begin
        case (memAddr) // RL6
          OFS_CONTROL: memRdData <= stateByte;
          OFS_SPARE2: memRdData <= {4'h0, faultShown};
          OFS_TARGET: memRdData <= echo_r; // RL25
          OFS_RATE: memRdData <= posS;
          OFS_STRENGTH: memRdData <= curS;
          default: memRdData <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator lamps
  grc_blink_if blinkBus ();
  grc_blinker #(.HALF_CYCLES(BLINK_CYCLES)) uBlink (
    .mclk(mclk),
    .resetn(resetn),
    .blink(blinkBus)
  );
  logic majorFault, minorFault;
  assign majorFault = state_r == ST_MAJOR;
  assign minorFault = !commS || state_r == ST_RELEASE;

  // Lamp registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ledSupply <= 1'b0;
      ledNetwork <= 1'b0;
      ledFault <= 1'b0;
    end else begin
      ledSupply <= pwrS; // RL1
      ledNetwork <= netS && (connS || blinkBus.blinkPhase); // RL2
      ledFault <= majorFault ? blinkBus.blinkPhase : minorFault; // RL3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_release_done;
    state_r == ST_RELEASE && limS && actBit;
  endsequence
  sequence s_move_accept;
    accept && actBit;
  endsequence

  a_clear_resets: assert property (!actBit |=> state_r == ST_RESET) // RL8
    else $error("Clearing activation did not reset");
  a_idle_no_motion: assert property (state_r == ST_RESET |-> !motorRun) // RL9
    else $error("Motion while not activated");
  a_release_wins: assert property ( // RL14
      state_r == ST_READY && actBit && releaseBit |=> state_r == ST_RELEASE)
    else $error("Release did not take priority");
  a_release_fault: assert property ( // RL13
      s_release_done |=> state_r == ST_MAJOR && fault_r == FLT_RELEASED)
    else $error("Release completion fault missing");
  a_major_holds: assert property ( // RL4
      state_r == ST_MAJOR && actBit |=> state_r == ST_MAJOR && !motorRun)
    else $error("Major fault left without reactivation");
  a_echo_accept: assert property (s_move_accept |=> echo_r == $past(target_r)) // RL21
    else $error("Echo not taken on accept");
  a_echo_stable: assert property (!accept |=> $stable(echo_r)) // RL25
    else $error("Echo changed without accept");
  a_go_needed: assert property (state_r == ST_READY && motorRun |-> moveBit) // RL11
    else $error("Ready motion without go bit");
  a_contact_ignore: assert property ( // RL19
      moving_r && !pastIgnore && !atTarget && moveBit && !releaseBit
      && state_r == ST_READY && curS < OVERCURRENT_LEVEL && actBit
      |=> moving_r)
    else $error("Stopped inside ignore travel");
  a_no_act_fault: assert property ( // RL24
      !actBit && moveBit |=> fault_r == FLT_NO_ACTIVATE)
    else $error("Missing no-activation fault");
  a_supply_lamp: assert property (syncB_r[SYNC_W-1] |=> ledSupply) // RL1
    else $error("Supply lamp dark while powered");
  a_act_echo: assert property ( // RL22
      memRdEn && memAddr == OFS_CONTROL |=> memRdData[0] == $past(actBit))
    else $error("Activation echo wrong");
endmodule // grc_gripper_core

// ===== logic/grc_pkg.sv
// Package of constants and types for the gripper command register logic
package grc_pkg;
  // Byte offsets of the command and status spaces
  localparam logic [2:0] OFS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_SPARE1 = 3'h1;
  localparam logic [2:0] OFS_SPARE2 = 3'h2;
  localparam logic [2:0] OFS_TARGET = 3'h3;
  localparam logic [2:0] OFS_RATE = 3'h4;
  localparam logic [2:0] OFS_STRENGTH = 3'h5;
  // Control byte field positions
  localparam int BIT_ACTIVATE = 0;
  localparam int BIT_MOVE = 3;
  localparam int BIT_RELEASE = 4;
  // Reset values of the command bytes
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_TARGET = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_STRENGTH = 8'h00;
  // Fault codes
  localparam logic [3:0] FLT_NONE = 4'h0;
  localparam logic [3:0] FLT_NOT_READY = 4'h5;
  localparam logic [3:0] FLT_NO_ACTIVATE = 4'h7;
  localparam logic [3:0] FLT_COMM_BOOT = 4'h9;
  localparam logic [3:0] FLT_RELEASING = 4'hB;
  localparam logic [3:0] FLT_OVERCURRENT = 4'hE;
  localparam logic [3:0] FLT_RELEASED = 4'hF;
  // Activation status and contact codes, bit order as read
  localparam logic [1:0] ACT_IDLE = 2'h0;
  localparam logic [1:0] ACT_BUSY = 2'h1;
  localparam logic [1:0] ACT_DONE = 2'h3;
  localparam logic [1:0] OBJ_MOVING = 2'h0;
  localparam logic [1:0] OBJ_OPEN_STOP = 2'h1;
  localparam logic [1:0] OBJ_CLOSE_STOP = 2'h2;
  localparam logic [1:0] OBJ_AT_TARGET = 2'h3;
  // Motion constants
  localparam logic [7:0] IGNORE_TRAVEL = 8'h08;
  localparam logic [8:0] CURRENT_FLOOR = 9'h020;
  localparam logic [7:0] OVERCURRENT_LEVEL = 8'hFF;
  localparam logic [7:0] RELEASE_RATE = 8'h10;
  localparam logic [7:0] HOMING_RATE = 8'h40;
  // Blink timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_ACTIVATE = 3'b001,
    ST_READY = 3'b010,
    ST_RELEASE = 3'b011,
    ST_MAJOR = 3'b100
  } grc_state_t;
endpackage

// ===== logic/grc_blink_if.sv
// Interface carrying the blink phase from the blink generator
interface grc_blink_if;
  logic blinkPhase;
  modport gen (output blinkPhase);
  modport sink (input blinkPhase);
endinterface

// ===== logic/grc_blinker.sv
// Blink phase generator for the indicator lamps
module grc_blinker import grc_pkg::*; #(
  parameter int HALF_CYCLES = BLINK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Blink phase out
  grc_blink_if.gen blink
);
  logic [31:0] divCount_r;
  logic phase_r;

  // Divider giving a one-cycle enable at each half period
  always_ff @(posedge mclk) begin
    if (!resetn || divCount_r == 32'(HALF_CYCLES - 1)) begin
      divCount_r <= '0;
    end else begin
      divCount_r <= divCount_r + 32'h1;
    end
  end

  // Phase toggles on each enable
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      phase_r <= 1'b0;
    end else if (divCount_r == 32'(HALF_CYCLES - 1)) begin
      phase_r <= ~phase_r;
    end
  end

  assign blink.blinkPhase = phase_r;
endmodule // grc_blinker

// ===== bench/grc_finger_model.sv
// Behavioural finger actuator that answers the core's motor drive
module grc_finger_model #(
  parameter logic [7:0] START_POS = 8'h80
) (
  // Clock
  input wire logic mclk,
  // Motor drive from the core
  input wire logic motorRun,
  input wire logic motorClose,
  // Obstacle placed by the bench
  input wire logic obstacleOn,
  input wire logic [7:0] obstaclePos,
  // Feedback to the core
  output logic [7:0] fingerPos,
  output logic [7:0] motorCurrent,
  output logic axesAtLimit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic touching;
  initial fingerPos = START_POS;
  // Contact once the closing fingers reach the obstacle
  assign touching = obstacleOn && (fingerPos >= obstaclePos);
  // Current climbs well above a low limit only while pressing on the obstacle
  assign motorCurrent = (touching && motorRun && motorClose) ? 8'h80 : 8'h10;
  // Open mechanical stop
  assign axesAtLimit = (fingerPos == 8'h00);
  // One count per cycle while driven, stalled by the obstacle or the stops
  always @(posedge mclk) begin
    if (motorRun && motorClose && !touching && fingerPos != 8'hFF) begin
      fingerPos <= fingerPos + 8'h01;
    end else if (motorRun && !motorClose && fingerPos != 8'h00) begin
      fingerPos <= fingerPos - 8'h01;
    end
  end
endmodule // grc_finger_model

// ===== bench/grc_gripper_core_tb.sv
// Self-checking testbench of the gripper command register core
module grc_gripper_core_tb import grc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic memWrEn = 1'b0;
  logic memRdEn = 1'b0;
  logic [2:0] memAddr = 3'h0;
  logic [7:0] memWrData = 8'h00;
  logic powerGood = 1'b0;
  logic netDetected = 1'b0;
  logic netConnected = 1'b0;
  logic commReady = 1'b0;
  logic obstacleOn = 1'b0;
  logic [7:0] memRdData, fingerPos, motorCurrent, motorRate, sRate;
  logic memRdValid, axesAtLimit, motorRun, motorClose, sRun, sClose;
  logic [8:0] currentLimit, sLimit;
  wire [2:0] leds;
  logic [7:0] expQ[$];
  int errCount = 0;
  int compares = 0;
  int seed = 64635;
  int n;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and finger actuator
  always #5 mclk = ~mclk;
  grc_gripper_core #(.BLINK_CYCLES(4)) grc_gripper_core_i (.mclk(mclk), .resetn(resetn),
    .memWrEn(memWrEn), .memRdEn(memRdEn), .memAddr(memAddr), .memWrData(memWrData),
    .memRdData(memRdData), .memRdValid(memRdValid), .powerGood(powerGood),
    .netDetected(netDetected), .netConnected(netConnected), .commReady(commReady),
    .fingerPos(fingerPos), .motorCurrent(motorCurrent), .axesAtLimit(axesAtLimit),
    .motorRun(motorRun), .motorClose(motorClose), .motorRate(motorRate),
    .currentLimit(currentLimit), .ledSupply(leds[2]), .ledNetwork(leds[1]),
    .ledFault(leds[0]));
  grc_finger_model grc_finger_model_i (.mclk(mclk), .motorRun(motorRun),
    .motorClose(motorClose), .obstacleOn(obstacleOn), .obstaclePos(8'h60),
    .fingerPos(fingerPos), .motorCurrent(motorCurrent), .axesAtLimit(axesAtLimit));
  // Settled copies of the combinational drive outputs
  always @(negedge mclk) begin
    sRun <= motorRun;
    sClose <= motorClose;
    sRate <= motorRate;
    sLimit <= currentLimit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    if (errCount == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic ticks(input int c);
    repeat (c) @(posedge mclk);
  endtask
  // One command byte write, then a free cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    memAddr <= a;
    memWrData <= d;
    memWrEn <= 1'b1;
    @(posedge mclk);
    memWrEn <= 1'b0;
    @(posedge mclk);
  endtask
  // One status byte read; the monitor compares the answer
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    expQ.push_back(exp);
    memAddr <= a;
    memRdEn <= 1'b1;
    @(posedge mclk);
    memRdEn <= 1'b0;
    @(posedge mclk);
  endtask
  // Bounded wait for the motor drive to reach a level
  task automatic waitRun(input logic lvl, input int lim);
    n = 0;
    while (sRun !== lvl && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk("motorRun", {8'h00, sRun}, {8'h00, lvl});
  endtask
  // Lamp mode over 16 cycles: 0 dark, 1 lit, 2 blinking
  task automatic lamp(input int idx, input logic [1:0] mode);
    int ones;
    ones = 0;
    repeat (16) begin
      @(negedge mclk);
      ones += (leds[idx] === 1'b1) ? 1 : 0;
    end
    @(posedge mclk);
    chk("lamp", (ones == 0) ? 9'h000 : (ones == 16) ? 9'h001 : 9'h002, {7'h00, mode});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read monitor takes the oldest note for every answer
  always @(posedge mclk) begin
    if (memRdValid === 1'b1) begin
      chk("status", {1'b0, memRdData}, {1'b0, expQ.pop_front()});
    end
  end
  // Watchdog
  initial begin
    #100us;
    errCount++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    ticks(8);
    resetn <= 1'b1;
    ticks(4);
    lamp(2, 2'h0);
    lamp(1, 2'h0);
    lamp(0, 2'h1);
    powerGood <= 1'b1;
    netDetected <= 1'b1;
    ticks(4);
    lamp(2, 2'h1);
    lamp(1, 2'h2);
    netConnected <= 1'b1;
    commReady <= 1'b1;
    ticks(4);
    lamp(1, 2'h1);
    lamp(0, 2'h0);
    // Spare and unmapped places ignore random data
    wr(3'h1, 8'($random(seed)));
    wr(3'h2, 8'($random(seed)));
    wr(3'h6, 8'($random(seed)));
    rd(3'h1, 8'h00);
    rd(3'h7, 8'h00);
    rd(3'h2, 8'h00);
    // Go without activation is refused
    wr(3'h0, 8'h08);
    ticks(3);
    chk("motorRun", {8'h00, sRun}, 9'h000);
    rd(3'h2, 8'h07);
    wr(3'h0, 8'h00);
    // Activation homes open; a go meanwhile gives fault 5
    wr(3'h0, 8'h01);
    waitRun(1'b1, 10);
    chk("close", {8'h00, sClose}, 9'h000);
    rd(3'h0, 8'h11);
    wr(3'h0, 8'h09);
    ticks(3);
    rd(3'h2, 8'h05);
    wr(3'h0, 8'h01);
    waitRun(1'b0, 300);
    ticks(4);
    // Settings alone move nothing
    wr(3'h4, 8'hFF);
    wr(3'h5, 8'h00);
    wr(3'h3, 8'h20);
    ticks(2);
    chk("motorRun", {8'h00, sRun}, 9'h000);
    chk("limit", sLimit, 9'h020);
    rd(3'h3, 8'h00);
    wr(3'h0, 8'h09);
    waitRun(1'b1, 6);
    chk("rate", {1'b0, sRate}, 9'h0FF);
    chk("close", {8'h00, sClose}, 9'h001);
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h20);
    waitRun(1'b0, 100);
    ticks(2);
    rd(3'h0, 8'hF9);
    // Closing onto an obstacle stops on the current limit
    obstacleOn <= 1'b1;
    wr(3'h5, 8'h10);
    ticks(1);
    chk("limit", sLimit, 9'h030);
    wr(3'h3, 8'hF0);
    waitRun(1'b1, 6);
    waitRun(1'b0, 200);
    ticks(2);
    rd(3'h0, 8'hB9);
    rd(3'h3, 8'hF0);
    // Release outranks go, ends in a major fault
    obstacleOn <= 1'b0;
    wr(3'h0, 8'h19);
    waitRun(1'b1, 6);
    chk("close", {8'h00, sClose}, 9'h000);
    chk("rate", {1'b0, sRate}, {1'b0, RELEASE_RATE});
    rd(3'h2, 8'h0B);
    waitRun(1'b0, 200);
    ticks(2);
    rd(3'h2, 8'h0F);
    lamp(0, 2'h2);
    wr(3'h3, 8'h80);
    ticks(4);
    chk("motorRun", {8'h00, sRun}, 9'h000);
    // Clearing activation clears the fault; a fresh activation recovers
    wr(3'h0, 8'h00);
    ticks(3);
    rd(3'h2, 8'h00);
    rd(3'h0, 8'h00);
    lamp(0, 2'h0);
    wr(3'h0, 8'h01);
    ticks(10);
    wr(3'h0, 8'h09);
    waitRun(1'b1, 6);
    waitRun(1'b0, 200);
    ticks(3);
    chk("pending", 9'(expQ.size()), 9'h000);
    results();
  end
endmodule // grc_gripper_core_tb
